/* File: hw/csit_pkg.sv */
/*
 File: constants for the clock select and interval timer block.
 Assumes: single 50 MHz clock domain, plain strobe register port.
*/
package csit_pkg;
    localparam int unsigned CSIT_ADDR_W = 8;
    localparam int unsigned CSIT_DATA_W = 8;
    localparam int unsigned CSIT_PDIV_W = 12;

    // Register offsets
    localparam logic [7:0] CSIT_OFF_OSC_SEL = 8'hbc;
    localparam logic [7:0] CSIT_OFF_CLK_CTRL = 8'hf2;
    localparam logic [7:0] CSIT_OFF_COUNT = 8'hf3;
    localparam logic [7:0] CSIT_OFF_IRQ_STATUS = 8'hf8;
    localparam logic [7:0] CSIT_OFF_IRQ_MASK = 8'hf9;

    // Reset values
    localparam logic [7:0] CSIT_RST_OSC_SEL = 8'h00;
    localparam logic [7:0] CSIT_RST_CLK_CTRL = 8'h17;
    localparam logic [7:0] CSIT_RST_IRQ_MASK = 8'h00;

    // oscillator_select fields
    localparam int unsigned CSIT_BIT_SYS_SEL = 0;
    localparam int unsigned CSIT_BIT_SUB_HALT = 1;
    localparam int unsigned CSIT_BIT_MAIN_HALT = 2;

    // interval_clock_control fields
    localparam int unsigned CSIT_BIT_SRC_LO = 0;
    localparam int unsigned CSIT_BIT_CLEAR = 3;
    localparam int unsigned CSIT_BIT_WDOG_ON = 4;

    // Interrupt status fields
    localparam int unsigned CSIT_BIT_IRQ_OVF = 0;

    // Smallest prescaler tap is divide by 8, i.e. bit 2 of the divider
    localparam int unsigned CSIT_TAP_BASE = 2;

    // Main oscillator source options (one-time configuration)
    typedef enum logic [2:0] {
        CSIT_SRC_XTAL,
        CSIT_SRC_EXT_RC,
        CSIT_SRC_IRC_8M,
        CSIT_SRC_IRC_4M,
        CSIT_SRC_IRC_2M,
        CSIT_SRC_IRC_1M
    } csit_main_src_t;
endpackage

/* File: hw/csit_top.sv */
/*
 File: clock selection, oscillator halt control, peripheral clock divider
 and 8-bit interval counter with overflow interrupt.
 Assumes: clk is the selected oscillator clock, inputs are synchronous to it,
 the CPU core gives a stop pulse and a wake pulse, and the watchdog
 logic consumes the time base and the watchdog mode bit.
*/
// Summary of operation
// - The system clock select bit picks the main oscillator at 0 and the sub oscillator at 1.
// - The main oscillator halt bit runs the main oscillator at 0 and stops it at 1.
// - The sub oscillator halt bit runs the sub oscillator at 0 and stops it at 1.
// - Peripherals get the source clock undivided and divided by every power of two from 2 to 4096.
// - A stop instruction gates the peripheral clock off and leaving stop gates it back on.
// - Stop halts only the oscillator chosen as system clock and leaves the other as it was.
// - The main oscillator source is fixed by a one-time option among crystal, external RC or internal RC 8/4/2/1 MHz.
// - The interval counter is an 8-bit free-running counter stepping on each prescaler pulse, held only in stop.
// - A rollover of the interval counter from ff to 00 raises the interval interrupt request.
// - Writing 1 to the clear bit zeroes the counter and the bit clears itself after one cycle.
// - The 3-bit source select picks the prescaler tap from divide by 8 at 000 to divide by 1024 at 111.
// - The watchdog on bit makes the downstream 7-bit counter a plain timer at 0 and a watchdog at 1.
// - The interval counter supplies the watchdog time base.
// - Software reads the live counter value through an 8-bit count register.
module csit_top #(
    parameter csit_pkg::csit_main_src_t MAIN_SRC = csit_pkg::CSIT_SRC_XTAL
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [csit_pkg::CSIT_ADDR_W-1:0] reg_addr,
    input wire logic [csit_pkg::CSIT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [csit_pkg::CSIT_DATA_W-1:0] reg_rdata,
    input wire logic stop_enter,
    input wire logic stop_wake,
    output logic sys_clk_sel,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic [2:0] main_osc_source,
    output logic periph_clk_en,
    output logic [csit_pkg::CSIT_PDIV_W:0] periph_clk_taps,
    output logic [7:0] interval_counter_value,
    output logic interval_tick,
    output logic watchdog_on,
    output logic interval_irq,
    output logic irq
);
    import csit_pkg::*;

    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;
    logic [7:0] osc_sel_q;
    logic [2:0] src_sel_q;
    logic clear_q;
    logic wdog_on_q;
    logic stopped_q;
    logic [CSIT_PDIV_W-1:0] div_q;
    logic [CSIT_PDIV_W-1:0] div_d;
    logic [7:0] count_q;
    logic tap_pulse;
    logic ovf;
    logic ovf_flag_q;
    logic ovf_mask_q;
    logic [7:0] rdata_d;

    // Reset is released through two flops so release is clean
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end
        else
        begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n = rst_sync2_q;

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = reg_wr && (reg_addr == off);
    endfunction

    // Oscillator select register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sel_q <= CSIT_RST_OSC_SEL;
        end
        else if (wr_hit(CSIT_OFF_OSC_SEL))
        begin
            osc_sel_q <= {5'h00, reg_wdata[2:0]};
        end
    end

    // Stop mode state; wake wins over a same-cycle entry
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stopped_q <= 1'b0;
        end
        else if (stop_wake)
        begin
            stopped_q <= 1'b0;
        end
        else if (stop_enter)
        begin
            stopped_q <= 1'b1;
        end
    end

    assign sys_clk_sel = osc_sel_q[CSIT_BIT_SYS_SEL];
    // Stop only affects the oscillator in use as system clock
    assign main_osc_run = !osc_sel_q[CSIT_BIT_MAIN_HALT] && !(stopped_q && !sys_clk_sel);
    assign sub_osc_run = !osc_sel_q[CSIT_BIT_SUB_HALT] && !(stopped_q && sys_clk_sel);
    assign main_osc_source = MAIN_SRC;
    assign periph_clk_en = !stopped_q;

    // Clock control register; clear bit is a self-clearing one-cycle pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_sel_q <= CSIT_RST_CLK_CTRL[2:0];
            wdog_on_q <= CSIT_RST_CLK_CTRL[CSIT_BIT_WDOG_ON];
        end
        else if (wr_hit(CSIT_OFF_CLK_CTRL))
        begin
            src_sel_q <= reg_wdata[2:0];
            wdog_on_q <= reg_wdata[CSIT_BIT_WDOG_ON];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clear_q <= CSIT_RST_CLK_CTRL[CSIT_BIT_CLEAR];
        end
        else
        begin
            clear_q <= wr_hit(CSIT_OFF_CLK_CTRL) && reg_wdata[CSIT_BIT_CLEAR];
        end
    end
    assign watchdog_on = wdog_on_q;

    // Shared prescaler; frozen while the peripheral clock is gated
    assign div_d = div_q + 12'h001;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
        end
        else if (!stopped_q)
        begin
            div_q <= div_d;
        end
    end

    // Tap k carries clk/2^k, tap 0 is the undivided enable level
    assign periph_clk_taps = {div_q, periph_clk_en};

    // Tap pulse fires when the low bits of the divider all wrap
    always_comb
    begin
        logic [CSIT_PDIV_W-1:0] lowmask;
        lowmask = '0;
        for (int i = 0; i < CSIT_PDIV_W; i++)
        begin
            if (i <= int'(src_sel_q) + CSIT_TAP_BASE)
            begin
                lowmask[i] = 1'b1;
            end
        end
        tap_pulse = !stopped_q && ((div_q & lowmask) == lowmask);
    end

    // Interval counter; a clear restarts from zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= 8'h00;
        end
        else if (clear_q)
        begin
            count_q <= 8'h00;
        end
        else if (tap_pulse)
        begin
            count_q <= count_q + 8'h01;
        end
    end

    assign ovf = tap_pulse && !clear_q && (count_q == 8'hff);
    assign interval_irq = ovf;
    assign interval_tick = tap_pulse && !clear_q;
    assign interval_counter_value = count_q;

    // Sticky overflow flag; a new overflow beats a read clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovf_flag_q <= 1'b0;
        end
        else if (ovf)
        begin
            ovf_flag_q <= 1'b1;
        end
        else if (reg_rd && reg_addr == CSIT_OFF_IRQ_STATUS)
        begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovf_mask_q <= CSIT_RST_IRQ_MASK[0];
        end
        else if (wr_hit(CSIT_OFF_IRQ_MASK))
        begin
            ovf_mask_q <= reg_wdata[CSIT_BIT_IRQ_OVF];
        end
    end
    assign irq = ovf_flag_q && ovf_mask_q;

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_addr == CSIT_OFF_OSC_SEL)
        begin
            rdata_d = osc_sel_q;
        end
        else if (reg_addr == CSIT_OFF_CLK_CTRL)
        begin
            rdata_d = {3'h0, wdog_on_q, clear_q, src_sel_q};
        end
        else if (reg_addr == CSIT_OFF_COUNT)
        begin
            rdata_d = count_q;
        end
        else if (reg_addr == CSIT_OFF_IRQ_STATUS)
        begin
            rdata_d = {7'h00, ovf_flag_q};
        end
        else if (reg_addr == CSIT_OFF_IRQ_MASK)
        begin
            rdata_d = {7'h00, ovf_mask_q};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end
endmodule

/* File: testbench/csit_checker.sv */
/*
 Port checker for csit_top.
 Assumes: bound to csit_top, single clock, resetn low resets.
*/
module csit_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic stop_enter,
    input wire logic stop_wake,
    input wire logic sys_clk_sel,
    input wire logic main_osc_run,
    input wire logic sub_osc_run,
    input wire logic periph_clk_en,
    input wire logic [12:0] periph_clk_taps,
    input wire logic [7:0] interval_counter_value,
    input wire logic interval_tick,
    input wire logic interval_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // The block keeps its own reset for two more edges after resetn rises
    logic [2:0] live_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            live_q <= 3'h0;
        end
        else
        begin
            live_q <= {live_q[1:0], 1'b1};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    stop_gate_a: assert property (stop_enter && !stop_wake |=> !periph_clk_en)
        else $error("stop left clock running");
    wake_gate_a: assert property (stop_wake |=> periph_clk_en)
        else $error("wake left clock gated");
    main_stop_a: assert property (!periph_clk_en && !sys_clk_sel |-> !main_osc_run)
        else $error("main osc runs in stop");
    sub_stop_a: assert property (!periph_clk_en && sys_clk_sel |-> !sub_osc_run)
        else $error("sub osc runs in stop");
    count_hold_a: assert property (!periph_clk_en |=> $stable(interval_counter_value))
        else $error("counter moved in stop");
    tick_step_a: assert property (interval_tick |=> interval_counter_value == $past(interval_counter_value) + 8'h01
        || interval_counter_value == 8'h00)
        else $error("tick did not step counter");
    tap_en_a: assert property (periph_clk_taps[0] == periph_clk_en)
        else $error("undivided tap not gated");
    irq_roll_a: assert property (interval_irq |-> interval_tick && interval_counter_value == 8'hff)
        else $error("interrupt without rollover");
    clear_zero_a: assert property (reg_wr && reg_addr == 8'hf2 && reg_wdata[3] |-> ##2 interval_counter_value == 8'h00)
        else $error("clear did not zero counter");
    tap_toggle_a: assert property (live_q[2] && $past(periph_clk_en) |-> periph_clk_taps[1] != $past(periph_clk_taps[1]))
        else $error("divide by 2 tap did not toggle");
    roll_c: cover property (interval_irq);
    stop_c: cover property (stop_enter);
    clear_c: cover property (reg_wr && reg_addr == 8'hf2 && reg_wdata[3]);
endmodule

bind csit_top csit_checker csit_checker_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .stop_enter, .stop_wake, .sys_clk_sel, .main_osc_run, .sub_osc_run, .periph_clk_en, .periph_clk_taps,
    .interval_counter_value, .interval_tick, .interval_irq);

/* File: testbench/csit_cpu_model.sv */
/*
 CPU core and watchdog stand-in: stop and wake pulses, tick counting.
 Assumes: bench raises the requests for one cycle.
*/
module csit_cpu_model (
    input wire logic clk,
    input wire logic stop_req,
    input wire logic wake_req,
    input wire logic interval_tick,
    output logic stop_enter,
    output logic stop_wake,
    output int tick_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int ticks = 0;
    assign tick_count = ticks;
    // Instructions reach the block one cycle after the core decodes them
    always @(posedge clk)
    begin
        stop_enter <= stop_req;
        stop_wake <= wake_req;
        if (interval_tick)
            ticks <= ticks + 1;
    end
endmodule

/* File: testbench/tb_csit_top.sv */
/*
 Self-checking bench for csit_top.
 Assumes: 50 MHz clock, registered read data, CPU model makes stop pulses.
*/
module tb_csit_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csit_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stop_req = 1'b0, wake_req = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, interval_counter_value;
    logic sys_clk_sel, main_osc_run, sub_osc_run, periph_clk_en, interval_tick, watchdog_on, interval_irq, irq;
    logic stop_enter, stop_wake;
    logic [2:0] main_osc_source;
    logic [12:0] periph_clk_taps;
    int tick_count, err_count = 0, checked = 0;
    csit_top #(.MAIN_SRC(CSIT_SRC_IRC_2M)) csit_top_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .stop_enter, .stop_wake, .sys_clk_sel, .main_osc_run, .sub_osc_run, .main_osc_source,
        .periph_clk_en, .periph_clk_taps, .interval_counter_value, .interval_tick, .watchdog_on, .interval_irq, .irq);
    csit_cpu_model csit_cpu_model_inst (.clk, .stop_req, .wake_req, .interval_tick, .stop_enter, .stop_wake,
        .tick_count);
    initial forever #10 clk = ~clk;
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bus tasks start and end just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("read data", exp, reg_rdata);
        @(posedge clk);
    endtask
    // Bounded wait on a pulse seen at the falling edge
    task automatic wait_hi(input bit irq_not_tick, output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while ((irq_not_tick ? interval_irq : interval_tick) !== 1'b1 && k < 3000);
        if (k >= 3000)
            chk("pulse wait", 1, 0);
    endtask
    task automatic t_reset;
        rd(CSIT_OFF_OSC_SEL, 8'h00);
        rd(CSIT_OFF_CLK_CTRL, 8'h17);
        rd(8'h40, 8'h00);
        chk("watchdog_on", 1, watchdog_on);
        chk("main_osc_source", CSIT_SRC_IRC_2M, main_osc_source);
        $display("reset values done");
    endtask
    task automatic t_osc;
        wr(CSIT_OFF_OSC_SEL, 8'hff);
        rd(CSIT_OFF_OSC_SEL, 8'h07);
        chk("sys_clk_sel", 1, sys_clk_sel);
        chk("main_osc_run", 0, main_osc_run);
        chk("sub_osc_run", 0, sub_osc_run);
        wr(CSIT_OFF_OSC_SEL, 8'h00);
        chk("osc runs", 2'b11, {main_osc_run, sub_osc_run});
        $display("oscillator control done");
    endtask
    task automatic t_stop;
        logic [7:0] c;
        logic [12:0] p;
        for (int s = 0; s < 2; s++)
        begin
            wr(CSIT_OFF_OSC_SEL, 8'(s));
            stop_req <= 1'b1;
            @(posedge clk);
            stop_req <= 1'b0;
            repeat (3) @(posedge clk);
            chk("stopped en", 0, periph_clk_en);
            chk("osc runs", {s[0], !s[0]}, {main_osc_run, sub_osc_run});
            c = interval_counter_value;
            p = periph_clk_taps;
            repeat (20) @(posedge clk);
            chk("frozen count", c, interval_counter_value);
            chk("frozen taps", 16'(p), 16'(periph_clk_taps));
            rd(CSIT_OFF_COUNT, c);
            wake_req <= 1'b1;
            @(posedge clk);
            wake_req <= 1'b0;
            repeat (3) @(posedge clk);
            chk("woken en", 1, periph_clk_en);
        end
        wr(CSIT_OFF_OSC_SEL, 8'h00);
        $display("stop mode done");
    endtask
    task automatic t_presc;
        int k;
        for (int s = 0; s < 8; s++)
        begin
            wr(CSIT_OFF_CLK_CTRL, 8'h10 | 8'(s));
            wait_hi(0, k);
            wait_hi(0, k);
            chk("tick period", 16'(1 << (s + 3)), 16'(k));
            @(posedge clk);
        end
        $display("prescaler taps done");
    endtask
    task automatic t_ovf;
        int k, t0;
        wr(CSIT_OFF_CLK_CTRL, 8'h10);
        wr(CSIT_OFF_IRQ_MASK, 8'h01);
        wait_hi(1, k);
        t0 = tick_count;
        @(negedge clk);
        chk("irq", 1, irq);
        @(posedge clk);
        rd(CSIT_OFF_IRQ_STATUS, 8'h01);
        chk("irq cleared", 0, irq);
        wr(CSIT_OFF_IRQ_MASK, 8'h00);
        wait_hi(1, k);
        chk("ticks per wrap", 256, 16'(tick_count - t0));
        @(negedge clk);
        chk("masked irq", 0, irq);
        @(posedge clk);
        rd(CSIT_OFF_IRQ_STATUS, 8'h01);
        rd(CSIT_OFF_IRQ_STATUS, 8'h00);
        $display("overflow interrupt done");
    endtask
    task automatic t_clear;
        wr(CSIT_OFF_CLK_CTRL, 8'h18);
        @(negedge clk);
        chk("cleared count", 0, interval_counter_value);
        @(posedge clk);
        rd(CSIT_OFF_CLK_CTRL, 8'h10);
        wr(CSIT_OFF_CLK_CTRL, 8'h00);
        chk("watchdog_on", 0, watchdog_on);
        rd(CSIT_OFF_CLK_CTRL, 8'h00);
        $display("clear and mode done");
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_osc;
        t_stop;
        t_presc;
        t_ovf;
        t_clear;
        conclude;
    end
    // Whole run needs about 8k cycles
    initial
    begin
        #1000000;
        err_count++;
        conclude;
    end
endmodule
